// >>> tb/dsc_dma_status_ctrl_tb.sv
// self-checking bench of the dma status and channel control block
`timescale 1ns/1ps
module dsc_dma_status_ctrl_tb;
	logic        mclk, rst_n, stop_entry, src_valid, src_ready, src_in_io;
	logic        src_is_dreg, dst_valid, dst_ready, dst_in_io, dst_is_dreg;
	logic        ext_stall, core_bank_req, wake_core, wait_block, slow;
	logic [5:0]  chan_en_set, chan_en_clr, channel_irq_enable, dma_trigger;
	logic [5:0]  wake_src_sel, channel_enable_bit, irq_req, irq_seen;
	logic [17:0] transfer_mode_field;
	logic [23:0] count_init, src_data, dst_data, dma_status, last_wr;
	logic [7:0]  core_bank, dma_bank;
	logic [2:0]  ch_seen;
	logic        wake_seen, act_seen;
	int          error_cnt, checked, rd_cnt, wr_cnt, w0, n;

	dsc_dma_status_ctrl uut (.mclk(mclk), .rst_n(rst_n),
		.chan_en_set(chan_en_set), .chan_en_clr(chan_en_clr),
		.channel_irq_enable(channel_irq_enable),
		.transfer_mode_field(transfer_mode_field), .count_init(count_init),
		.dma_trigger(dma_trigger), .wake_src_sel(wake_src_sel),
		.stop_entry(stop_entry), .src_valid(src_valid), .src_ready(src_ready),
		.src_data(src_data), .src_in_io(src_in_io), .src_is_dreg(src_is_dreg),
		.dst_valid(dst_valid), .dst_ready(dst_ready), .dst_data(dst_data),
		.dst_in_io(dst_in_io), .dst_is_dreg(dst_is_dreg),
		.ext_stall(ext_stall), .core_bank_req(core_bank_req),
		.core_bank(core_bank), .dma_bank(dma_bank), .dma_status(dma_status),
		.channel_enable_bit(channel_enable_bit), .irq_req(irq_req),
		.wake_core(wake_core), .wait_block(wait_block));
	dsc_mem_model mem (.mclk(mclk), .rst_n(rst_n), .slow(slow),
		.src_ready(src_ready), .src_valid(src_valid), .src_data(src_data),
		.dst_valid(dst_valid), .dst_ready(dst_ready), .dst_data(dst_data),
		.rd_cnt(rd_cnt), .wr_cnt(wr_cnt), .last_wr(last_wr));

	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [23:0] exp_word(input int k);
		return 24'h3c0000 ^ 24'(k);
	endfunction : exp_word

	task automatic stop_test;
		$display("counts: checked %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : stop_test

	task automatic cmp_v(input string nm, input logic [23:0] e, input logic [23:0] g);
		checked++;
		if (g !== e)
		begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp_v

	task automatic cmp_n(input string nm, input int e, input int g);
		checked++;
		if (g != e)
		begin
			error_cnt++;
			$display("MISMATCH %s expected %0d seen %0d", nm, e, g);
		end
	endtask : cmp_n

	task automatic tick(input int k);
		repeat (k) @(negedge mclk);
	endtask : tick

	// enables a channel and follows the delayed done clear
	task automatic arm(input int ch, input logic [23:0] cnt, input logic [2:0] md);
		transfer_mode_field[3*ch +: 3] = md;
		count_init = cnt;
		chan_en_set[ch] = 1'b1;
		tick(1);
		chan_en_set = 6'h00;
		cmp_v("enable", 24'h1, channel_enable_bit[ch]);
		// done still reads one up to the third edge after the set edge
		for (int k = 1; k <= 3; k++)
		begin
			cmp_v("done", 24'h1, dma_status[ch]);
			tick(1);
		end
		cmp_v("done", 24'h0, dma_status[ch]);
		w0 = wr_cnt;
		irq_seen = 6'h00;
		wake_seen = 1'b0;
		act_seen = 1'b0;
	endtask : arm

	task automatic trig(input int ch);
		dma_trigger[ch] = 1'b1;
		tick(1);
		dma_trigger = 6'h00;
	endtask : trig

	task automatic wait_for(input int ch, input bit on_irq);
		int i;
		i = 0;
		while ((on_irq ? irq_seen[ch] : dma_status[ch]) !== 1'b1 && i < 400)
		begin
			tick(1);
			i++;
		end
		if (i == 400)
		begin
			error_cnt++;
			$display("MISMATCH wait ch%0d expected set seen timeout", ch);
			stop_test();
		end
	endtask : wait_for

	// ----------------------------------------------------------------
	// event monitor
	// ----------------------------------------------------------------
	always @(posedge mclk)
	begin
		irq_seen <= irq_seen | irq_req;
		wake_seen <= wake_seen | wake_core;
		if (dma_status[8] === 1'b1)
		begin
			act_seen <= 1'b1;
			ch_seen <= dma_status[11:9];
		end
		if (rst_n)
			cmp_v("wait_block", dma_status[8], wait_block);
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		{rst_n, stop_entry, src_in_io, dst_in_io, ext_stall} = 5'h00;
		{src_is_dreg, dst_is_dreg, core_bank_req, slow} = 4'h0;
		{chan_en_set, chan_en_clr, channel_irq_enable} = 18'h00000;
		{dma_trigger, wake_src_sel, transfer_mode_field} = 30'h00000000;
		{count_init, core_bank, dma_bank} = 40'h0000000000;
		{irq_seen, wake_seen, act_seen, ch_seen} = 11'h000;
		error_cnt = 0;
		checked = 0;
		void'($urandom(61112));
		repeat (6) @(posedge mclk);
		tick(1);
		rst_n = 1'b1;
		cmp_v("status", dsc_pkg::STATUS_RST, dma_status);
		for (int ch = 0; ch < 6; ch++)
		begin
			// single-word block on channel 0 is the boundary case
			n = (ch == 0) ? 0 : $urandom_range(5, 1);
			slow = 1'($urandom_range(1, 0));
			channel_irq_enable = 6'($urandom);
			arm(ch, 24'(n), 3'h0);
			trig(ch);
			wait_for(ch, 0);
			tick(2);
			cmp_n("words", n + 1, wr_cnt - w0);
			cmp_v("last word", exp_word(wr_cnt - 1), last_wr);
			cmp_v("enable", 24'h0, channel_enable_bit[ch]);
			cmp_v("irq", channel_irq_enable & (6'h01 << ch), irq_seen);
			cmp_v("channel", ch, ch_seen);
			cmp_v("active seen", 24'h1, act_seen);
			cmp_v("active", 24'h0, dma_status[8]);
			cmp_v("reserved", 24'h0, {dma_status[23:12], dma_status[7:6]});
			$display("test block ch%0d done", ch);
		end
		channel_irq_enable = 6'h02;
		arm(1, 24'h1, 3'h4);
		trig(1);
		wait_for(1, 1);
		tick(2);
		cmp_n("words", 2, wr_cnt - w0);
		cmp_v("enable", 24'h1, channel_enable_bit[1]);
		cmp_v("done", 24'h0, dma_status[1]);
		chan_en_clr[1] = 1'b1;
		tick(1);
		chan_en_clr = 6'h00;
		wait_for(1, 0);
		$display("test continuous done");
		arm(2, 24'h3, 3'h1);
		trig(2);
		tick(12);
		cmp_n("words", 1, wr_cnt - w0);
		cmp_v("done", 24'h0, dma_status[2]);
		trig(2);
		chan_en_clr[2] = 1'b1;
		tick(1);
		chan_en_clr = 6'h00;
		wait_for(2, 0);
		tick(2);
		cmp_n("words", 2, wr_cnt - w0);
		cmp_v("enable", 24'h0, channel_enable_bit[2]);
		$display("test word mode done");
		// stop is entered while busy so that a trigger sits latched
		wake_src_sel = 6'h10;
		arm(5, 24'h0, 3'h0);
		arm(4, 24'h2, 3'h0);
		ext_stall = 1'b1;
		trig(4);
		tick(8);
		cmp_n("words", 0, wr_cnt - w0);
		cmp_v("active", 24'h1, dma_status[8]);
		cmp_v("wake", 24'h1, wake_seen);
		trig(5);
		tick(2);
		stop_entry = 1'b1;
		tick(1);
		stop_entry = 1'b0;
		ext_stall = 1'b0;
		wait_for(4, 0);
		tick(20);
		cmp_n("words", 3, wr_cnt - w0);
		cmp_v("done", 24'h0, dma_status[5]);
		cmp_v("active", 24'h0, dma_status[8]);
		chan_en_clr[5] = 1'b1;
		tick(1);
		chan_en_clr = 6'h00;
		wait_for(5, 0);
		$display("test stop done");
		{core_bank_req, core_bank, dma_bank} = 17'h12424;
		arm(0, 24'h3, 3'h0);
		trig(0);
		tick(10);
		cmp_n("words", 0, wr_cnt - w0);
		core_bank = 8'h13;
		wait_for(0, 0);
		tick(2);
		cmp_n("words", 4, wr_cnt - w0);
		core_bank_req = 1'b0;
		$display("test bank done");
		dst_in_io = 1'b1;
		arm(3, 24'h1, 3'h0);
		trig(3);
		wait_for(3, 0);
		tick(2);
		cmp_n("words", 0, wr_cnt - w0);
		{dst_in_io, src_in_io} = 2'h1;
		arm(3, 24'h1, 3'h0);
		trig(3);
		wait_for(3, 0);
		tick(2);
		cmp_n("words", 2, wr_cnt - w0);
		cmp_v("io word", 24'h0, last_wr);
		$display("test io space done");
		stop_test();
	end
endmodule : dsc_dma_status_ctrl_tb

// >>> tb/dsc_mem_model.sv
// memory-side partner model: source word supplier and destination sink
`timescale 1ns/1ps
module dsc_mem_model
(
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        slow,
	input  wire logic        src_ready,
	output logic             src_valid,
	output logic      [23:0] src_data,
	input  wire logic        dst_valid,
	output logic             dst_ready,
	input  wire logic [23:0] dst_data,
	output int               rd_cnt,
	output int               wr_cnt,
	output logic      [23:0] last_wr
);
	logic [1:0] gap_reg;

	// ----------------------------------------------------------------
	// source and sink behaviour
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			src_valid <= 1'b0;
			src_data  <= 24'h000000;
			dst_ready <= 1'b0;
			gap_reg   <= 2'h0;
			rd_cnt    <= 0;
			wr_cnt    <= 0;
			last_wr   <= 24'h000000;
		end
		else
		begin
			// a slow sink toggles ready so held write data is exercised
			dst_ready <= slow ? ~dst_ready : 1'b1;
			if (src_valid && src_ready)
			begin
				// released data is inverted so stale values never match
				src_valid <= 1'b0;
				src_data  <= ~src_data;
				rd_cnt    <= rd_cnt + 1;
				gap_reg   <= slow ? 2'h2 : 2'h0;
			end
			else if (!src_valid && gap_reg != 2'h0)
				gap_reg <= gap_reg - 2'h1;
			else if (!src_valid)
			begin
				src_valid <= 1'b1;
				src_data  <= 24'h3c0000 ^ 24'(rd_cnt);
			end
			if (dst_valid && dst_ready)
			begin
				wr_cnt  <= wr_cnt + 1;
				last_wr <= dst_data;
			end
		end
	end
endmodule : dsc_mem_model

// >>> verilog/dsc_dma_status_ctrl.sv
// six-channel dma status, done flags, channel enable and transfer sequencing
`timescale 1ns/1ps
module dsc_dma_status_ctrl
#(
	parameter int CW     = 24,
	parameter int DW     = 24,
	parameter int BW     = 8,
	parameter int FDEPTH = 8
)
(
	input  wire logic                         mclk,
	input  wire logic                         rst_n,
	input  wire logic [dsc_pkg::NCH-1:0]      chan_en_set,
	input  wire logic [dsc_pkg::NCH-1:0]      chan_en_clr,
	input  wire logic [dsc_pkg::NCH-1:0]      channel_irq_enable,
	input  wire logic [dsc_pkg::NCH*3-1:0]    transfer_mode_field,
	input  wire logic [CW-1:0]                count_init,
	input  wire logic [dsc_pkg::NCH-1:0]      dma_trigger,
	input  wire logic [dsc_pkg::NCH-1:0]      wake_src_sel,
	input  wire logic                         stop_entry,
	input  wire logic                         src_valid,
	output logic                              src_ready,
	input  wire logic [DW-1:0]                src_data,
	input  wire logic                         src_in_io,
	input  wire logic                         src_is_dreg,
	output logic                              dst_valid,
	input  wire logic                         dst_ready,
	output logic      [DW-1:0]                dst_data,
	input  wire logic                         dst_in_io,
	input  wire logic                         dst_is_dreg,
	input  wire logic                         ext_stall,
	input  wire logic                         core_bank_req,
	input  wire logic [BW-1:0]                core_bank,
	input  wire logic [BW-1:0]                dma_bank,
	output logic      [dsc_pkg::STATUS_W-1:0] dma_status,
	output logic      [dsc_pkg::NCH-1:0]      channel_enable_bit,
	output logic      [dsc_pkg::NCH-1:0]      irq_req,
	output logic                              wake_core,
	output logic                              wait_block
);
	localparam int N = dsc_pkg::NCH;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic io_ok(input logic in_io, input logic is_dreg);
		// i/o space is open only for peripheral data registers
		return !in_io || is_dreg;
	endfunction : io_ok

	function automatic logic [2:0] pick_lowest(input logic [N-1:0] v);
		logic [2:0] r;
		r = '0;
		for (int i = N - 1; i >= 0; i--)
			if (v[i])
				r = 3'(i);
		return r;
	endfunction : pick_lowest

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	dsc_pkg::dsc_state_t st_reg, st_next;
	logic [2:0]          ch_reg, ch_next;
	logic [N-1:0]        en_reg, en_next;
	logic [N-1:0]        pend_reg, pend_next;
	logic [N-1:0]        drain_reg, drain_next;
	logic [N-1:0]        done_reg, done_next;
	logic [N-1:0]        irq_reg, irq_next;
	logic                wake_reg, wake_next;
	logic [1:0]          clr_reg [N];
	logic [1:0]          clr_next [N];
	logic [CW-1:0]       cnt_reg [N];
	logic [CW-1:0]       cnt_next [N];
	logic [CW-1:0]       init_reg [N];
	logic [CW-1:0]       init_next [N];
	logic [dsc_pkg::STATUS_W-1:0] status_reg, status_next;

	logic [N-1:0] word_m, cont_m, done_set, fin_blk, elig;
	logic         stall, src_ok, dst_ok;
	logic         f_in_valid, f_in_ready, f_out_valid, f_out_ready;
	logic [DW-1:0] f_in_data, f_out_data;
	logic         push, pop, last;

	genvar g;
	generate
		for (g = 0; g < N; g++)
		begin : g_mode
			assign word_m[g] = transfer_mode_field[g*3 + dsc_pkg::TM_WORD_BIT];
			assign cont_m[g] = transfer_mode_field[g*3 + dsc_pkg::TM_CONT_BIT];
		end
	endgenerate

	// ----------------------------------------------------------------
	// data path
	// ----------------------------------------------------------------
	// one shared access path: any stall holds every channel
	assign stall  = ext_stall || (core_bank_req && core_bank == dma_bank);
	assign src_ok = io_ok(src_in_io, src_is_dreg);
	assign dst_ok = io_ok(dst_in_io, dst_is_dreg);

	// a refused i/o source yields zero instead of touching the pin
	assign f_in_valid = (st_reg == dsc_pkg::DSC_READ) && !stall
		&& (src_valid || !src_ok);
	assign f_in_data  = src_ok ? src_data : '0;
	assign src_ready  = (st_reg == dsc_pkg::DSC_READ) && !stall && src_ok
		&& f_in_ready;
	assign push       = f_in_valid && f_in_ready;

	// a refused destination word is dropped, never written
	assign dst_valid   = (st_reg == dsc_pkg::DSC_WRITE) && f_out_valid
		&& !stall && dst_ok;
	assign f_out_ready = (st_reg == dsc_pkg::DSC_WRITE) && !stall
		&& (dst_ready || !dst_ok);
	assign pop         = f_out_valid && f_out_ready;
	assign dst_data    = f_out_data;

	dsc_fifo #(.W(DW), .D(FDEPTH)) u_fifo (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.in_valid  (f_in_valid),
		.in_ready  (f_in_ready),
		.in_data   (f_in_data),
		.out_valid (f_out_valid),
		.out_ready (f_out_ready),
		.out_data  (f_out_data)
	);

	assign last = (cnt_reg[ch_reg] == '0);

	// ----------------------------------------------------------------
	// channel control and sequencing
	// ----------------------------------------------------------------
	always_comb
	begin
		st_next    = st_reg;
		ch_next    = ch_reg;
		en_next    = en_reg;
		pend_next  = pend_reg;
		drain_next = drain_reg;
		done_next  = done_reg;
		cnt_next   = cnt_reg;
		init_next  = init_reg;
		clr_next   = clr_reg;
		done_set   = '0;
		fin_blk    = '0;
		wake_next  = 1'b0;
		elig       = pend_reg & (en_reg | drain_reg);

		for (int i = 0; i < N; i++)
		begin
			// done clears on the third edge after enable
			if (clr_reg[i] != '0)
				clr_next[i] = clr_reg[i] - 2'h1;
			if (clr_reg[i] == 2'h1)
				done_next[i] = 1'b0;
			if (dma_trigger[i] && en_reg[i])
				pend_next[i] = 1'b1;
			if (chan_en_clr[i] && en_reg[i])
			begin
				en_next[i]  = 1'b0;
				clr_next[i] = '0;
				// software disable is a last transfer too
				if ((st_reg != dsc_pkg::DSC_IDLE && ch_reg == 3'(i))
					|| (word_m[i] && pend_reg[i]))
					drain_next[i] = 1'b1;
				else
				begin
					done_set[i]  = 1'b1;
					pend_next[i] = 1'b0;
				end
			end
		end

		case (st_reg)
			dsc_pkg::DSC_IDLE:
			begin
				if (elig != '0)
				begin
					ch_next = pick_lowest(elig);
					pend_next[ch_next] = dma_trigger[ch_next]
						&& en_reg[ch_next];
					wake_next = wake_src_sel[ch_next];
					st_next = dsc_pkg::DSC_READ;
				end
			end
			dsc_pkg::DSC_READ:
			begin
				if (push)
					st_next = dsc_pkg::DSC_WRITE;
			end
			dsc_pkg::DSC_WRITE:
			begin
				if (pop)
				begin
					st_next = dsc_pkg::DSC_IDLE;
					if (last)
					begin
						cnt_next[ch_reg] = init_reg[ch_reg];
						fin_blk[ch_reg]  = 1'b1;
						if (!cont_m[ch_reg])
						begin
							done_set[ch_reg] = 1'b1;
							en_next[ch_reg]  = 1'b0;
						end
					end
					else
					begin
						cnt_next[ch_reg] = cnt_reg[ch_reg] - 1'b1;
						if (!word_m[ch_reg] && en_reg[ch_reg]
							&& !drain_reg[ch_reg])
							st_next = dsc_pkg::DSC_READ;
					end
					if (drain_reg[ch_reg])
					begin
						done_set[ch_reg]   = 1'b1;
						drain_next[ch_reg] = 1'b0;
					end
				end
			end
			default:
				st_next = dsc_pkg::DSC_IDLE;
		endcase

		if (stop_entry)
			pend_next = '0;

		for (int i = 0; i < N; i++)
			if (chan_en_set[i])
			begin
				en_next[i]   = 1'b1;
				cnt_next[i]  = count_init;
				init_next[i] = count_init;
				clr_next[i]  = dsc_pkg::DONE_CLR_CYC;
			end

		// a hardware set beats the delayed clear
		done_next = done_next | done_set;
		irq_next  = (done_set | fin_blk) & channel_irq_enable;

		status_next = '0;
		status_next[dsc_pkg::DONE_LSB +: N] = done_next;
		status_next[dsc_pkg::ACT_BIT] = (st_next != dsc_pkg::DSC_IDLE);
		status_next[dsc_pkg::CH_LSB +: dsc_pkg::CH_W] = ch_next;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_reg     <= dsc_pkg::DSC_IDLE;
			ch_reg     <= '0;
			en_reg     <= '0;
			pend_reg   <= '0;
			drain_reg  <= '0;
			done_reg   <= dsc_pkg::DONE_RST;
			irq_reg    <= '0;
			wake_reg   <= 1'b0;
			status_reg <= dsc_pkg::STATUS_RST;
			for (int i = 0; i < N; i++)
			begin
				clr_reg[i]  <= '0;
				cnt_reg[i]  <= '0;
				init_reg[i] <= '0;
			end
		end
		else
		begin
			st_reg     <= st_next;
			ch_reg     <= ch_next;
			en_reg     <= en_next;
			pend_reg   <= pend_next;
			drain_reg  <= drain_next;
			done_reg   <= done_next;
			irq_reg    <= irq_next;
			wake_reg   <= wake_next;
			status_reg <= status_next;
			clr_reg    <= clr_next;
			cnt_reg    <= cnt_next;
			init_reg   <= init_next;
		end
	end

	assign dma_status         = status_reg;
	assign channel_enable_bit = en_reg;
	assign irq_req            = irq_reg;
	assign wake_core          = wake_reg;
	// wait entry refused while a transfer is under way
	assign wait_block = status_reg[dsc_pkg::ACT_BIT];

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_act_tracks_busy: assert property (@(posedge mclk) disable iff (!rst_n)
		(st_reg != dsc_pkg::DSC_IDLE) |-> dma_status[dsc_pkg::ACT_BIT])
		else $error("active bit low during transfer");

	a_act_idle_low: assert property (@(posedge mclk) disable iff (!rst_n)
		(st_reg == dsc_pkg::DSC_IDLE) |-> !dma_status[dsc_pkg::ACT_BIT])
		else $error("active bit high while idle");

	a_chan_in_range: assert property (@(posedge mclk) disable iff (!rst_n)
		dma_status[dsc_pkg::ACT_BIT]
		|-> dma_status[dsc_pkg::CH_LSB +: dsc_pkg::CH_W] <= dsc_pkg::CH_LAST)
		else $error("active channel field out of range");

	a_reserved_zero: assert property (@(posedge mclk) disable iff (!rst_n)
		dma_status[dsc_pkg::RSV_LSB +: dsc_pkg::RSV_W] == '0
		&& dma_status[dsc_pkg::HI_LSB +: dsc_pkg::HI_W] == '0)
		else $error("reserved status bits not zero");

	a_done_at_end: assert property (@(posedge mclk) disable iff (!rst_n)
		(st_reg == dsc_pkg::DSC_WRITE && pop && last && !cont_m[ch_reg])
		|=> dma_status[dsc_pkg::DONE_LSB + $past(ch_reg)]
		&& !channel_enable_bit[$past(ch_reg)] && !chan_en_set[$past(ch_reg)]
		or chan_en_set[$past(ch_reg)] || $past(chan_en_set[ch_reg]))
		else $error("block end did not set done and clear enable");

	a_irq_at_end: assert property (@(posedge mclk) disable iff (!rst_n)
		(st_reg == dsc_pkg::DSC_WRITE && pop && last
		&& channel_irq_enable[ch_reg]) |=> irq_req[$past(ch_reg)])
		else $error("end of block without interrupt request");

	a_done_clr_delay: assert property (@(posedge mclk) disable iff (!rst_n)
		(chan_en_set[0] && done_reg[0] && done_set == '0
		&& !chan_en_clr[0]) ##1 (chan_en_clr[0] == 1'b0)[*2]
		|=> done_reg[0] ##1 (!done_reg[0] || $past(done_set[0])))
		else $error("done bit not cleared three cycles after enable");

	a_stop_drops: assert property (@(posedge mclk) disable iff (!rst_n)
		stop_entry |=> pend_reg == '0)
		else $error("latched trigger survived stop entry");

	a_stall_holds: assert property (@(posedge mclk) disable iff (!rst_n)
		stall |-> !dst_valid && !src_ready)
		else $error("transfer moved during stall");

	a_io_guard: assert property (@(posedge mclk) disable iff (!rst_n)
		(dst_valid |-> dst_ok) and (src_ready |-> src_ok))
		else $error("access to non data register in i/o space");

	a_wake_on_accept: assert property (@(posedge mclk) disable iff (!rst_n)
		(st_reg == dsc_pkg::DSC_IDLE && elig != '0
		&& wake_src_sel[pick_lowest(elig)]) |=> wake_core ##1 !wake_core
		or st_reg == dsc_pkg::DSC_IDLE)
		else $error("accepted trigger did not wake core");

endmodule : dsc_dma_status_ctrl

// >>> verilog/dsc_fifo.sv
// word fifo between the source read and the destination write
`timescale 1ns/1ps
module dsc_fifo
#(
	parameter int W = 24,
	parameter int D = 8
)
(
	input  wire logic         mclk,
	input  wire logic         rst_n,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	localparam int AW = $clog2(D);

	logic [W-1:0] mem_reg [D];
	logic [W-1:0] mem_next [D];
	logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
	logic [AW:0]   cnt_reg, cnt_next;
	logic          push, pop;

	assign in_ready  = (cnt_reg != (AW+1)'(D));
	assign out_valid = (cnt_reg != '0);
	assign out_data  = mem_reg[rp_reg];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb
	begin
		mem_next = mem_reg;
		wp_next  = wp_reg;
		rp_next  = rp_reg;
		if (push)
		begin
			mem_next[wp_reg] = in_data;
			wp_next = (wp_reg == AW'(D-1)) ? '0 : wp_reg + 1'b1;
		end
		if (pop)
			rp_next = (rp_reg == AW'(D-1)) ? '0 : rp_reg + 1'b1;
		cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < D; i++)
				mem_reg[i] <= '0;
			wp_reg  <= '0;
			rp_reg  <= '0;
			cnt_reg <= '0;
		end
		else
		begin
			mem_reg <= mem_next;
			wp_reg  <= wp_next;
			rp_reg  <= rp_next;
			cnt_reg <= cnt_next;
		end
	end

	a_fifo_no_overrun: assert property (@(posedge mclk) disable iff (!rst_n)
		cnt_reg <= (AW+1)'(D))
		else $error("fifo count above depth");

endmodule : dsc_fifo

// >>> verilog/dsc_pkg.sv
// shared constants and types of the dma status and channel control block
package dsc_pkg;

	// ----------------------------------------------------------------
	// channels and status register layout
	// ----------------------------------------------------------------
	localparam int          NCH         = 6;
	localparam int          STATUS_W    = 24;
	localparam int          DONE_LSB    = 0;
	localparam int          RSV_LSB     = 6;
	localparam int          RSV_W       = 2;
	localparam int          ACT_BIT     = 8;
	localparam int          CH_LSB      = 9;
	localparam int          CH_W        = 3;
	localparam int          HI_LSB      = 12;
	localparam int          HI_W        = 12;
	localparam logic [5:0]  DONE_RST    = 6'h3f;
	localparam logic [23:0] STATUS_RST  = 24'h00003f;
	localparam logic [2:0]  CH_LAST     = 3'h5;

	// ----------------------------------------------------------------
	// transfer mode field decode
	// ----------------------------------------------------------------
	localparam int          TM_W        = 3;
	localparam int          TM_WORD_BIT = 0;
	localparam int          TM_CONT_BIT = 2;

	// ----------------------------------------------------------------
	// timing: one instruction cycle per mclk cycle
	// ----------------------------------------------------------------
	localparam int          CLK_MHZ        = 100;
	localparam int          DONE_CLR_INSTR = 3;
	localparam logic [1:0]  DONE_CLR_CYC   = 2'(DONE_CLR_INSTR);

	typedef enum logic [1:0] {
		DSC_IDLE,
		DSC_READ,
		DSC_WRITE
	} dsc_state_t;

endpackage : dsc_pkg
